// *** core/imm_add_pkg.sv ***
// Overview of operation
// [RULE_01] An instruction word whose upper byte is 0000 1111 is the immediate add, its low byte the operand.
// [RULE_02] The operand is an unsigned byte and every value from 0 to 255 is accepted.
// [RULE_03] The sum of accumulator and operand is written back to the accumulator only.
// [RULE_04] Exactly the negative, overflow, carry, digit carry and zero flags change; other status bits hold.
// [RULE_05] The instruction is one word and completes in one instruction cycle with no extra fetch or idle.
// [RULE_06] Phase one decodes, phase two reads the operand, phase three adds, phase four writes.
// [RULE_07] Carry is out of bit 7, digit carry out of bit 3, overflow is signed, negative is bit 7, zero is all-zero.
package imm_add_pkg;
  localparam logic [7:0] OPCODE_HI  = 8'h0f;
  localparam int         FLAG_C     = 0;
  localparam int         FLAG_DC    = 1;
  localparam int         FLAG_Z     = 2;
  localparam int         FLAG_OV    = 3;
  localparam int         FLAG_N     = 4;
  localparam logic [7:0] FLAG_MASK  = 8'h1f;
  localparam logic [7:0] ACC_RESET  = 8'h00;
  localparam logic [7:0] STAT_RESET = 8'h00;

  typedef enum logic [1:0] {PH_DECODE, PH_READ, PH_PROCESS, PH_WRITE} phase_t;

  typedef struct packed {
    logic [7:0] sum;
    logic       c;
    logic       dc;
    logic       z;
    logic       ov;
    logic       n;
  } add_res_t;
endpackage

// *** core/immediate_add_op.sv ***
`timescale 1ns/1ns
module immediate_add_op (
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  input  wire logic [15:0] instr_i,
  input  wire logic        acc_load_i,
  input  wire logic [7:0]  acc_load_data_i,
  output logic      [7:0]  acc_o,
  output logic      [7:0]  status_o,
  output logic      [1:0]  phase_o,
  output logic             cycle_end_o,
  output logic             exec_done_o
);
  imm_add_pkg::phase_t phase;
  logic                hit;
  logic [7:0]          operand;
  imm_add_pkg::add_res_t res;

  // Full add with all five flags
  function automatic imm_add_pkg::add_res_t add8(input logic [7:0] a, input logic [7:0] b);
    imm_add_pkg::add_res_t r;
    logic [8:0] s;
    logic [4:0] l;
    s      = {1'b0, a} + {1'b0, b};
    l      = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    r.sum  = s[7:0];
    r.c    = s[8];                                // [RULE_07]
    r.dc   = l[4];                                // [RULE_07]
    r.z    = (s[7:0] == 8'h00);                   // [RULE_07]
    r.ov   = (a[7] == b[7]) && (s[7] != a[7]);    // [RULE_07]
    r.n    = s[7];                                // [RULE_07]
    return r;
  endfunction

  // Opcode match on the upper byte only; any low byte is a valid operand
  wire logic       next_hit     = (instr_i[15:8] == imm_add_pkg::OPCODE_HI); // [RULE_01]
  wire logic [7:0] next_operand = instr_i[7:0];                              // [RULE_02]
  wire logic [7:0] next_status  = (status_o & ~imm_add_pkg::FLAG_MASK) |
                                  {3'h0, res.n, res.ov, res.z, res.dc, res.c}; // [RULE_04]

  // Phase decode shared by the datapath, the write-back and the checks
  wire logic       in_decode    = (phase == imm_add_pkg::PH_DECODE);
  wire logic       in_read      = (phase == imm_add_pkg::PH_READ);
  wire logic       in_process   = (phase == imm_add_pkg::PH_PROCESS);
  wire logic       in_write     = (phase == imm_add_pkg::PH_WRITE);
  wire logic       add_write    = in_write && hit; // The add owns the accumulator at this edge

  // Four-phase sequencer, one phase per clock; it never stalls
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      phase <= imm_add_pkg::PH_DECODE;
    end else begin
      case (phase)
        imm_add_pkg::PH_DECODE:  phase <= imm_add_pkg::PH_READ;
        imm_add_pkg::PH_READ:    phase <= imm_add_pkg::PH_PROCESS;
        imm_add_pkg::PH_PROCESS: phase <= imm_add_pkg::PH_WRITE;
        imm_add_pkg::PH_WRITE:   phase <= imm_add_pkg::PH_DECODE; // [RULE_05]
        default:                 phase <= imm_add_pkg::PH_DECODE;
      endcase
    end
  end

  // Datapath stages tied to phases; the upper byte of instr_i is sampled in decode, the low byte in read
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      hit     <= 1'b0;
      operand <= 8'h00;
      res     <= '0;
    end else begin
      if (in_decode) hit <= next_hit;                 // [RULE_06]
      if (in_read) operand <= next_operand;           // [RULE_06]
      if (in_process) res <= add8(acc_o, operand);    // [RULE_06]
    end
  end

  // Write-back in the last phase; an external load yields to the add
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      acc_o       <= imm_add_pkg::ACC_RESET;
      status_o    <= imm_add_pkg::STAT_RESET;
      exec_done_o <= 1'b0;
    end else begin
      exec_done_o <= 1'b0;
      if (add_write) begin
        acc_o       <= res.sum;     // [RULE_03]
        status_o    <= next_status; // [RULE_04]
        exec_done_o <= 1'b1;        // [RULE_05]
      end else if (acc_load_i) begin
        acc_o <= acc_load_data_i;
      end
    end
  end

  // Registered phase view for the fetch side
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      phase_o     <= 2'h0;
      cycle_end_o <= 1'b0;
    end else begin
      phase_o     <= phase;
      cycle_end_o <= in_write;
    end
  end

  // Accumulator as it stood at the process edge, kept only for the checks below
  logic [7:0] acc_at_process;
  always_ff @(posedge clk_i) begin
    if (srst_i) acc_at_process <= 8'h00;
    else if (in_process) acc_at_process <= acc_o;
  end

  // Reference terms for the checks, worked out apart from add8 so a slip there shows
  wire logic [8:0] chk_sum = {1'b0, acc_at_process} + {1'b0, operand};
  wire logic [4:0] chk_low = {1'b0, acc_at_process[3:0]} + {1'b0, operand[3:0]};
  wire logic       chk_ovf = (acc_at_process[7] == operand[7]) && (chk_sum[7] != acc_at_process[7]);

  // Reset leaves the sequencer in decode with a clear accumulator and status
  reset_state_a: assert property (@(posedge clk_i) disable iff (srst_i) // [RULE_06]
    $past(srst_i) |-> in_decode && !exec_done_o
      && acc_o == imm_add_pkg::ACC_RESET && status_o == imm_add_pkg::STAT_RESET)
    else $error("state after reset wrong");

  // The add result lands in the accumulator and nowhere else

  sum_written_a: assert property (@(posedge clk_i) disable iff (srst_i) // [RULE_03]
    exec_done_o |-> acc_o == 8'(acc_at_process + operand))
    else $error("accumulator does not hold the sum");

  // A matching word is written three edges after decode, seen at the fourth edge just after the write edge
  decode_match_a: assert property (@(posedge clk_i) disable iff (srst_i) // [RULE_01]
    (in_decode && instr_i[15:8] == imm_add_pkg::OPCODE_HI) |-> ##4 exec_done_o)
    else $error("matching opcode did not execute");
  // Near misses in the upper byte must leave no trace
  no_match_a: assert property (@(posedge clk_i) disable iff (srst_i) // [RULE_01]
    (in_decode && instr_i[15:8] != imm_add_pkg::OPCODE_HI) |-> ##4 !exec_done_o)
    else $error("foreign opcode executed");
  operand_taken_a: assert property (@(posedge clk_i) disable iff (srst_i) // [RULE_02]
    (phase == imm_add_pkg::PH_READ) |=> operand == $past(instr_i[7:0]))
    else $error("operand not taken from low byte");
  other_bits_a: assert property (@(posedge clk_i) disable iff (srst_i) // [RULE_04]
    status_o[7:5] == 3'h0)
    else $error("unrelated status bits changed");
  flag_rules_a: assert property (@(posedge clk_i) disable iff (srst_i) // [RULE_07]
    exec_done_o |-> status_o[4] == acc_o[7] && status_o[2] == (acc_o == 8'h00)
      && status_o[0] == ({1'b0, acc_at_process} + {1'b0, operand} > 9'h0ff))
    else $error("flag value wrong");
  one_cycle_a: assert property (@(posedge clk_i) disable iff (srst_i) // [RULE_05]
    exec_done_o |=> !exec_done_o [*3])
    else $error("execute spacing wrong");
  phase_order_a: assert property (@(posedge clk_i) disable iff (srst_i) // [RULE_06]
    (phase == imm_add_pkg::PH_DECODE) |=> phase == imm_add_pkg::PH_READ ##1
      phase == imm_add_pkg::PH_PROCESS ##1 phase == imm_add_pkg::PH_WRITE)
    else $error("phase order broken");

  // A load at the write edge of an add loses, or the sum would be thrown away
  load_yield_a: assert property (@(posedge clk_i) disable iff (srst_i) // [RULE_03]
    (add_write && acc_load_i) |=> exec_done_o && acc_o == res.sum)
    else $error("load overrode the add");

  // The accumulator moves only on an add or a load
  acc_hold_a: assert property (@(posedge clk_i) disable iff (srst_i) // [RULE_03]
    ($changed(acc_o) && !$past(srst_i)) |-> exec_done_o || $past(acc_load_i))
    else $error("accumulator changed without cause");

  // Status moves only when an add is written
  status_hold_a: assert property (@(posedge clk_i) disable iff (srst_i) // [RULE_04]
    ($changed(status_o) && !$past(srst_i)) |-> exec_done_o)
    else $error("status changed without an add");

  // A refused word leaves the status and the done pulse alone
  refused_hold_a: assert property (@(posedge clk_i) disable iff (srst_i) // [RULE_01]
    (in_write && !hit) |=> !exec_done_o && $stable(status_o))
    else $error("refused word touched the status");

  // The decode edge keeps the match for the rest of the cycle
  hit_capture_a: assert property (@(posedge clk_i) disable iff (srst_i) // [RULE_01]
    in_decode |=> hit == ($past(instr_i[15:8]) == imm_add_pkg::OPCODE_HI))
    else $error("opcode match not captured");

  // The operand holds between read edges, so a late word change cannot leak in
  operand_hold_a: assert property (@(posedge clk_i) disable iff (srst_i) // [RULE_02]
    !in_read |=> $stable(operand))
    else $error("operand changed outside the read phase");

  // The sum is formed at the process edge from the accumulator of that edge
  res_capture_a: assert property (@(posedge clk_i) disable iff (srst_i) // [RULE_06]
    in_process |=> res.sum == chk_sum[7:0])
    else $error("sum not formed in the process phase");

  // Digit carry is the carry out of the low nibble
  dc_flag_a: assert property (@(posedge clk_i) disable iff (srst_i) // [RULE_07]
    exec_done_o |-> status_o[imm_add_pkg::FLAG_DC] == chk_low[4])
    else $error("digit carry wrong");

  // Signed overflow when like signs give an unlike result
  ovf_flag_a: assert property (@(posedge clk_i) disable iff (srst_i) // [RULE_07]
    exec_done_o |-> status_o[imm_add_pkg::FLAG_OV] == chk_ovf)
    else $error("overflow flag wrong");

  // Instruction cycles follow one another with no idle gap
  cycle_rate_a: assert property (@(posedge clk_i) disable iff (srst_i) // [RULE_05]
    cycle_end_o |=> !cycle_end_o [*3] ##1 cycle_end_o)
    else $error("instruction cycle spacing wrong");

  // An add completes within its own instruction cycle
  done_at_end_a: assert property (@(posedge clk_i) disable iff (srst_i) // [RULE_05]
    exec_done_o |-> cycle_end_o)
    else $error("add finished outside its cycle");

  // The add writes the accumulator only at the fourth phase
  write_phase_a: assert property (@(posedge clk_i) disable iff (srst_i) // [RULE_06]
    exec_done_o |-> $past(in_write))
    else $error("write outside the fourth phase");

  // The phase view lags the sequencer by one clock
  phase_view_a: assert property (@(posedge clk_i) disable iff (srst_i) // [RULE_06]
    phase_o == $past(phase))
    else $error("phase view out of step");

  // Main outcomes: any add, carry out, signed overflow, zero result, digit carry
  exec_c:  cover property (@(posedge clk_i) disable iff (srst_i) exec_done_o);
  carry_c: cover property (@(posedge clk_i) disable iff (srst_i) exec_done_o && status_o[0]);
  ovf_c:   cover property (@(posedge clk_i) disable iff (srst_i) exec_done_o && status_o[3]);
  zero_c:  cover property (@(posedge clk_i) disable iff (srst_i) exec_done_o && status_o[2]);
  digit_c: cover property (@(posedge clk_i) disable iff (srst_i) exec_done_o && status_o[1]);
endmodule

// *** bench/fetch_model.sv ***
`timescale 1ns/1ns
// Fetch unit plus register-file seeding: each entry is {acc seed, instruction word}
module fetch_model (
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  output logic      [15:0] instr_o,
  output logic             acc_load_o = 1'b0,
  output logic      [7:0]  acc_load_data_o = 8'h00
);
  logic [23:0] q[$];
  logic [23:0] cur = 24'h0;
  logic [1:0]  cnt = 2'h0;
  assign instr_o = cur[15:0]; // One word held for the whole slot
  // Next word after the write edge; seed lands at the read edge, ahead of the add
  // Seed offered again at the write edge: a foreign word just reloads it, an add must win
  always @(posedge clk_i) begin
    cnt <= srst_i ? 2'h0 : cnt + 2'h1;
    if (srst_i || cnt == 2'h3) cur <= #1 (q.size() > 0 ? q.pop_front() : 24'h0);
    acc_load_o <= #1 !srst_i && (cnt == 2'h0 || cnt == 2'h2);
    acc_load_data_o <= #1 cur[23:16];
  end
endmodule

// *** bench/immediate_add_op_tb.sv ***
`timescale 1ns/1ns
module immediate_add_op_tb;
  logic        clk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic [15:0] instr;
  logic        load;
  logic        done;
  logic        cyc_end;
  logic [1:0]  ph;
  logic [7:0]  load_data, acc, status, exp_st;
  logic [23:0] ent[$];
  int          err_total = 0;
  int          checked = 0;
  always #4 clk_i = ~clk_i;
  fetch_model feed (.clk_i(clk_i), .srst_i(srst_i), .instr_o(instr), .acc_load_o(load), .acc_load_data_o(load_data));
  immediate_add_op dut (.clk_i(clk_i), .srst_i(srst_i), .instr_i(instr), .acc_load_i(load),
    .acc_load_data_i(load_data), .acc_o(acc), .status_o(status), .phase_o(ph), .cycle_end_o(cyc_end),
    .exec_done_o(done));
  // Reference add: {status, sum}, status bits N OV Z DC C from bit 4 down
  function automatic logic [15:0] ref_add(input logic [7:0] a, input logic [7:0] k);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, k};
    return {3'h0, s[7], a[7] == k[7] && s[7] != a[7], s[7:0] == 8'h00, a[3:0] + k[3:0] > 5'h0f, s[8], s[7:0]};
  endfunction
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checked %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Corners (walk example, carries, signed overflow, near-miss opcodes), then random words
  initial begin
    logic [15:0] r;
    void'($urandom(32'h9e1ca4d0));
    repeat (20) @(posedge clk_i);
    #1 srst_i = 1'b0;
    check("acc reset", acc, 8'h00);
    check("status reset", status, 8'h00);
    exp_st = 8'h00;
    ent = '{24'h100f15, 24'h010fff, 24'h7f0f01, 24'h800f80, 24'h0f0f01, 24'h550e15, 24'h551f00, 24'h558f00};
    repeat (40) ent.push_back({8'($urandom), $urandom_range(1) ? 8'h0f : 8'($urandom), 8'($urandom)});
    feed.q = ent;
    @(posedge clk_i iff feed.cnt == 2'h3);
    foreach (ent[i]) begin
      @(posedge clk_i iff feed.cnt == 2'h2);
      #2 check("acc before write", acc, ent[i][23:16]);
      check("phase at process", {6'h0, ph}, 8'(imm_add_pkg::PH_PROCESS));
      check("cycle end early", {7'h0, cyc_end}, 8'h00);
      @(posedge clk_i);
      r = ref_add(ent[i][23:16], ent[i][7:0]);
      if (ent[i][15:8] == 8'h0f) exp_st = r[15:8];
      #2 check("acc", acc, ent[i][15:8] == 8'h0f ? r[7:0] : ent[i][23:16]);
      check("status", status, exp_st);
      check("done", {7'h0, done}, {7'h0, ent[i][15:8] == 8'h0f});
      check("phase at write", {6'h0, ph}, 8'(imm_add_pkg::PH_WRITE));
      check("cycle end", {7'h0, cyc_end}, 8'h01);
      if (i == 7) $display("corner cases done");
    end
    $display("random words done");
    end_of_test();
  end
  // Watchdog: about 50 slots of 4 cycles plus reset fit well inside this span
  initial begin
    #20000;
    err_total++;
    end_of_test();
  end
endmodule
